// ==== pkg/wdt_defines.svh ====
// register offsets, option bits and timing figures of the watchdog
// assumes inclusion by bare name from each file that needs a constant
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// bus widths
`define WDT_ADDR_WIDTH      4
`define WDT_DATA_WIDTH      16

// register word offsets
`define WDT_REG_CMD         4'h0
`define WDT_REG_LOAD1       4'h1
`define WDT_REG_LOAD2       4'h2
`define WDT_REG_OPTIONS     4'h3
`define WDT_REG_STATUS      4'h4
`define WDT_REG_COUNT       4'h5

// command bits, write only
`define WDT_CMD_ENABLE      0
`define WDT_CMD_DISABLE     1
`define WDT_CMD_RETRIGGER   2

// option bits; meaning of each depends on the board variant
`define WDT_OPT_WIDTH       5
`define WDT_OPT_EDGE        0
`define WDT_OPT_INT         1
`define WDT_OPT_OUT         2
`define WDT_OPT_IN          3
`define WDT_OPT_RESET       4
`define WDT_OPT_MASK_A      5'h0f
`define WDT_OPT_MASK_B      5'h1f

// status bits and count field position
`define WDT_ST_ARMED        0
`define WDT_ST_DELAY        1
`define WDT_ST_FIRED        2
`define WDT_ST_TIMEOUT      3
`define WDT_ST_CONFIGURED   4
`define WDT_COUNT_DELAY_LSB 8

// counter widths and timebase
`define WDT_PRIMARY_WIDTH   6
`define WDT_DELAY_WIDTH     8
`define WDT_TICK_PERIOD_NS  30518
`define WDT_CLK_PERIOD_NS   50

`endif

// ==== pkg/wdt_pkg.sv ====
// types shared by the watchdog modules
// assumes nothing beyond a SystemVerilog compiler
package wdt_pkg;

    // one-hot watchdog sequence
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_RUN   = 4'h2,
        ST_DELAY = 4'h4,
        ST_FIRED = 4'h8
    } state_type;

endpackage

// ==== pkg/wdt_event_if.sv ====
// carrier for timebase tick and retrigger pin edges
// assumes all three pulses are one clk_in cycle wide
`timescale 1ns/10ps
interface wdt_event_if;
    logic rise;
    logic fall;
    logic tick;

    modport edge_src (output rise, output fall);
    modport tick_src (output tick);
    modport sink     (input rise, input fall, input tick);
endinterface // wdt_event_if

// ==== design/wdt_edge_sync.sv ====
// three-stage synchroniser and edge detector for the retrigger pin
// assumes the pin is asynchronous to clk_in
`timescale 1ns/10ps
module wdt_edge_sync (
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    input  wire logic  pin_in,
    wdt_event_if.edge_src ev
);
    logic [2:0] sync_q;
    logic       level_q;
    logic       rise_q;
    logic       fall_q;
    logic       agree;

    // stage 0 feeds stage 1 only
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) sync_q <= 3'h0;
        else           sync_q <= {sync_q[1:0], pin_in};
    end

    assign agree = (sync_q[1] == sync_q[2]);

    // a change counts once stages 1 and 2 agree
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            level_q <= 1'h0;
            rise_q  <= 1'h0;
            fall_q  <= 1'h0;
        end else begin
            if (agree) level_q <= sync_q[2];
            rise_q <= agree && sync_q[2] && !level_q;
            fall_q <= agree && !sync_q[2] && level_q;
        end
    end

    assign ev.rise = rise_q;
    assign ev.fall = fall_q;
endmodule // wdt_edge_sync

// ==== design/wdt_tick_gen.sv ====
// divider that makes the slow watchdog timebase from clk_in
// assumes clk_in runs free
`timescale 1ns/10ps
module wdt_tick_gen #(
    parameter int TICK_CYCLES = 610
) (
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    wdt_event_if.tick_src ev
);
    localparam int CW = $clog2(TICK_CYCLES);

    logic [CW-1:0] cnt_q;
    logic          tick_q;
    logic          wrap;

    assign wrap = (cnt_q == CW'(TICK_CYCLES - 1));

    // one-cycle tick every TICK_CYCLES clocks
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q  <= '0;
            tick_q <= 1'h0;
        end else begin
            cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
            tick_q <= wrap;
        end
    end

    assign ev.tick = tick_q;
endmodule // wdt_tick_gen

// ==== design/dual_stage_watchdog.sv ====
// two-stage watchdog: primary countdown, then reset delay countdown
// assumes a 20 MHz clk_in, synchronous active-low reset, plain reg port
//
// Functional notes
// - variant A: edge-select set means rising edge retriggers, else falling.
// - variant A: SMI option raises SMI when primary countdown expires.
// - variant A: output-pulse option pulses timeout output before trigger.
// - variant A: input-pulse option drives a pulse on retrigger line.
// - variant B: NMI option raises NMI when primary countdown expires.
// - immediate-reset option asserts hardware reset at primary expiry.
// - otherwise delay countdown runs; its timeout asserts hardware reset.
// - variant B: edge-select set means falling edge retriggers, else rising.
// - early option asserts timeout one tick before primary expiry.
// - without early option timeout asserts in the expiry cycle.
// - external enable lets qualifying pin edges reload primary countdown.
// - external enable clear means pin ignored, software retrigger only.
// - retrigger reloads both countdowns with their configured values.
// - software retrigger while disabled re-arms with last enabled options and current loads.
// - primary countdown is 6 bits on a ~32 kHz timebase.
// - delay countdown is 8 bits on the same timebase.
// - enable loads both countdowns, latches options and arms.
// - disable stops timing out but keeps stored configuration.
`include "wdt_defines.svh"
`timescale 1ns/10ps
module dual_stage_watchdog import wdt_pkg::*; #(
    parameter bit VARIANT_B     = 1'b1,
    parameter int TICK_CYCLES   = `WDT_TICK_PERIOD_NS / `WDT_CLK_PERIOD_NS,
    parameter int PRIMARY_WIDTH = `WDT_PRIMARY_WIDTH,
    parameter int DELAY_WIDTH   = `WDT_DELAY_WIDTH
) (
    input  wire logic                       clk_in,
    input  wire logic                       rst_n_in,
    input  wire logic [`WDT_ADDR_WIDTH-1:0] addr_in,
    input  wire logic [`WDT_DATA_WIDTH-1:0] wr_data_in,
    input  wire logic                       wr_strobe_in,
    input  wire logic                       rd_strobe_in,
    output logic      [`WDT_DATA_WIDTH-1:0] rd_data_out,
    input  wire logic                       external_retrigger_input_in,
    output logic                            external_retrigger_input_out,
    output logic                            external_retrigger_oe_n_out,
    output logic                            timeout_output_out,
    output logic                            hw_reset_out,
    output logic                            smi_out,
    output logic                            nmi_out
);
    localparam logic [`WDT_OPT_WIDTH-1:0] OPT_MASK =
        VARIANT_B ? `WDT_OPT_MASK_B : `WDT_OPT_MASK_A;

    wdt_event_if ev ();

    state_type                  state_q;
    logic [PRIMARY_WIDTH-1:0]   primary_countdown_q;
    logic [DELAY_WIDTH-1:0]     reset_delay_countdown_q;
    logic [PRIMARY_WIDTH-1:0]   load1_q;
    logic [DELAY_WIDTH-1:0]     load2_q;
    logic [`WDT_OPT_WIDTH-1:0]  opt_stage_q;
    logic [`WDT_OPT_WIDTH-1:0]  opt_q;
    logic                       configured_q;
    logic [`WDT_DATA_WIDTH-1:0] rd_data_q;
    logic [`WDT_DATA_WIDTH-1:0] rd_mux;
    logic                       timeout_q;
    logic                       hw_reset_q;
    logic                       smi_q;
    logic                       nmi_q;
    logic                       line_drive_q;
    logic                       line_oe_n_q;

    // timebase and pin conditioning
    wdt_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .ev       (ev)
    );

    wdt_edge_sync u_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .pin_in   (external_retrigger_input_in),
        .ev       (ev)
    );

    // option views per variant
    logic variant_a_rising_edge_select;
    logic variant_a_smi_on_timeout;
    logic variant_a_output_pulse_enable;
    logic variant_a_input_pulse_enable;
    logic variant_b_nmi_on_timeout;
    logic variant_b_immediate_reset;
    logic variant_b_falling_edge_select;
    logic variant_b_early_output;
    logic variant_b_external_retrigger_enable;

    assign variant_a_rising_edge_select  = !VARIANT_B && opt_q[`WDT_OPT_EDGE];
    assign variant_a_smi_on_timeout      = !VARIANT_B && opt_q[`WDT_OPT_INT];
    assign variant_a_output_pulse_enable = !VARIANT_B && opt_q[`WDT_OPT_OUT];
    assign variant_a_input_pulse_enable  = !VARIANT_B && opt_q[`WDT_OPT_IN];
    assign variant_b_nmi_on_timeout      = VARIANT_B && opt_q[`WDT_OPT_INT];
    assign variant_b_immediate_reset     = VARIANT_B && opt_q[`WDT_OPT_RESET];
    assign variant_b_falling_edge_select = VARIANT_B && opt_q[`WDT_OPT_EDGE];
    assign variant_b_early_output        = VARIANT_B && opt_q[`WDT_OPT_OUT];
    assign variant_b_external_retrigger_enable =
        VARIANT_B && opt_q[`WDT_OPT_IN];

    // command decode; disable beats enable beats retrigger
    logic cmd_wr;
    logic enable_cmd;
    logic disable_cmd;
    logic sw_retrig;
    logic ext_edge;
    logic ext_retrig;
    logic reload;
    logic stay;
    logic prewarn;
    logic expire_now;
    logic delay_done;
    logic fire_now;

    assign cmd_wr      = wr_strobe_in && (addr_in == `WDT_REG_CMD);
    assign disable_cmd = cmd_wr && wr_data_in[`WDT_CMD_DISABLE];
    assign enable_cmd  = cmd_wr && wr_data_in[`WDT_CMD_ENABLE] && !disable_cmd;
    // undefined before first enable, so simply ignored
    assign sw_retrig   = cmd_wr && wr_data_in[`WDT_CMD_RETRIGGER] && configured_q
                         && !disable_cmd && !enable_cmd;

    // qualifying edge; variant A has no enable bit and always listens
    assign ext_edge = VARIANT_B
        ? (variant_b_falling_edge_select ? ev.fall : ev.rise)
        : (variant_a_rising_edge_select ? ev.rise : ev.fall);
    assign ext_retrig = ext_edge && (!VARIANT_B || variant_b_external_retrigger_enable)
                        && (state_q inside {ST_RUN, ST_DELAY})
                        && !cmd_wr;

    assign reload     = sw_retrig || ext_retrig;
    assign stay       = !disable_cmd && !enable_cmd && !reload;
    assign prewarn    = (state_q == ST_RUN) && (primary_countdown_q == '0);
    assign expire_now = stay && prewarn && ev.tick;
    assign delay_done = stay && (state_q == ST_DELAY) && ev.tick
                        && (reset_delay_countdown_q == '0);
    assign fire_now   = (expire_now && variant_b_immediate_reset) || delay_done;

    // watchdog sequence
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
        end else if (disable_cmd) begin
            state_q <= ST_IDLE;
        end else if (enable_cmd || reload) begin
            state_q <= ST_RUN;
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    if (expire_now)
                        state_q <= variant_b_immediate_reset ? ST_FIRED : ST_DELAY;
                end
                ST_DELAY: begin
                    if (delay_done) state_q <= ST_FIRED;
                end
                ST_IDLE, ST_FIRED: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // primary countdown, stepped once per tick only while running
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            primary_countdown_q <= '0;
        end else if (!disable_cmd && (enable_cmd || reload)) begin
            primary_countdown_q <= load1_q;
        end else if (state_q == ST_RUN && ev.tick && !prewarn) begin
            primary_countdown_q <= primary_countdown_q - 1'b1;
        end
    end

    // delay countdown; reloaded with primary so a pin retrigger in
    // the delay stage does not leave it half spent
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            reset_delay_countdown_q <= '0;
        end else if (!disable_cmd && (enable_cmd || reload)) begin
            reset_delay_countdown_q <= load2_q;
        end else if (state_q == ST_DELAY && ev.tick && reset_delay_countdown_q != '0) begin
            reset_delay_countdown_q <= reset_delay_countdown_q - 1'b1;
        end
    end

    // software-written load values and staged options
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            load1_q     <= '0;
            load2_q     <= '0;
            opt_stage_q <= '0;
        end else if (wr_strobe_in) begin
            if (addr_in == `WDT_REG_LOAD1) load1_q <= wr_data_in[PRIMARY_WIDTH-1:0];
            if (addr_in == `WDT_REG_LOAD2) load2_q <= wr_data_in[DELAY_WIDTH-1:0];
            if (addr_in == `WDT_REG_OPTIONS)
                opt_stage_q <= wr_data_in[`WDT_OPT_WIDTH-1:0] & OPT_MASK;
        end
    end

    // options take effect only at enable and survive disable
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            opt_q        <= '0;
            configured_q <= 1'h0;
        end else if (enable_cmd) begin
            opt_q        <= opt_stage_q;
            configured_q <= 1'h1;
        end
    end

    // event outputs, registered from the next-state terms
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            hw_reset_q <= 1'h0;
            smi_q      <= 1'h0;
            nmi_q      <= 1'h0;
        end else begin
            hw_reset_q <= fire_now || (stay && state_q == ST_FIRED);
            smi_q      <= expire_now && variant_a_smi_on_timeout;
            nmi_q      <= expire_now && variant_b_nmi_on_timeout;
        end
    end

    // timeout output; early mode gives one tick of warning so a
    // loopback to the pin can retrigger before expiry
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            timeout_q <= 1'h0;
        end else if (VARIANT_B) begin
            timeout_q <= (stay && (expire_now || state_q inside {ST_DELAY, ST_FIRED}))
                         || (stay && prewarn && variant_b_early_output);
        end else begin
            timeout_q <= stay && prewarn && !ev.tick && variant_a_output_pulse_enable;
        end
    end

    // variant A pre-trigger pulse driven onto the retrigger line
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            line_drive_q <= 1'h0;
            line_oe_n_q  <= 1'h1;
        end else begin
            line_drive_q <= stay && prewarn && !ev.tick && variant_a_input_pulse_enable;
            line_oe_n_q  <= !(stay && prewarn && !ev.tick && variant_a_input_pulse_enable);
        end
    end

    // read mux; unmapped offsets and the command word read zero
    always_comb begin
        rd_mux = '0;
        unique case (addr_in)
            `WDT_REG_LOAD1:   rd_mux[PRIMARY_WIDTH-1:0] = load1_q;
            `WDT_REG_LOAD2:   rd_mux[DELAY_WIDTH-1:0] = load2_q;
            `WDT_REG_OPTIONS: rd_mux[`WDT_OPT_WIDTH-1:0] = opt_stage_q;
            `WDT_REG_STATUS: begin
                rd_mux[`WDT_ST_ARMED]      = state_q inside {ST_RUN, ST_DELAY};
                rd_mux[`WDT_ST_DELAY]      = (state_q == ST_DELAY);
                rd_mux[`WDT_ST_FIRED]      = (state_q == ST_FIRED);
                rd_mux[`WDT_ST_TIMEOUT]    = timeout_q;
                rd_mux[`WDT_ST_CONFIGURED] = configured_q;
            end
            `WDT_REG_COUNT: begin
                rd_mux[PRIMARY_WIDTH-1:0] = primary_countdown_q;
                rd_mux[`WDT_COUNT_DELAY_LSB +: DELAY_WIDTH] = reset_delay_countdown_q;
            end
            default: rd_mux = '0;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) rd_data_q <= '0;
        else           rd_data_q <= rd_strobe_in ? rd_mux : '0;
    end

    assign rd_data_out                  = rd_data_q;
    assign timeout_output_out           = timeout_q;
    assign hw_reset_out                 = hw_reset_q;
    assign smi_out                      = smi_q;
    assign nmi_out                      = nmi_q;
    assign external_retrigger_input_out = line_drive_q;
    assign external_retrigger_oe_n_out  = line_oe_n_q;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_imm_reset;
        expire_now && variant_b_immediate_reset |=> hw_reset_out && state_q == ST_FIRED;
    endproperty
    a_imm_reset: assert property (p_imm_reset) else $error("no immediate reset");

    property p_delay_stage;
        expire_now && !variant_b_immediate_reset |=> !hw_reset_out && state_q == ST_DELAY;
    endproperty
    a_delay_stage: assert property (p_delay_stage) else $error("delay stage skipped");

    property p_delay_fire;
        delay_done |=> hw_reset_out ##1 (hw_reset_out || !$past(stay));
    endproperty
    a_delay_fire: assert property (p_delay_fire) else $error("delay timeout lost");

    property p_smi;
        expire_now |=> smi_out == (!VARIANT_B && $past(opt_q[`WDT_OPT_INT]));
    endproperty
    a_smi: assert property (p_smi) else $error("smi mismatch");

    property p_nmi;
        expire_now |=> nmi_out == (VARIANT_B && $past(opt_q[`WDT_OPT_INT]));
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi mismatch");

    property p_early;
        prewarn && stay && variant_b_early_output |=> timeout_output_out;
    endproperty
    a_early: assert property (p_early) else $error("early timeout missing");

    property p_late;
        VARIANT_B && !variant_b_early_output && state_q == ST_RUN && !expire_now
            |=> !timeout_output_out;
    endproperty
    a_late: assert property (p_late) else $error("timeout too early");

    property p_retrig_reload;
        sw_retrig |=> primary_countdown_q == $past(load1_q)
                      && reset_delay_countdown_q == $past(load2_q) && state_q == ST_RUN;
    endproperty
    a_retrig_reload: assert property (p_retrig_reload) else $error("reload failed");

    property p_hold_idle;
        state_q == ST_IDLE && !enable_cmd && !reload
            |=> $stable(primary_countdown_q);
    endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("count moved idle");

    property p_ext_ignored;
        VARIANT_B && !variant_b_external_retrigger_enable && ev.rise && ev.fall == 1'b0
            && !cmd_wr && state_q == ST_RUN && !ev.tick
            |=> $stable(primary_countdown_q);
    endproperty
    a_ext_ignored: assert property (p_ext_ignored) else $error("pin not ignored");

    c_expire:  cover property (expire_now);
    c_fired:   cover property (delay_done);
    c_ext:     cover property (ext_retrig);
    c_rearm:   cover property (state_q == ST_IDLE && sw_retrig);
endmodule // dual_stage_watchdog

// ==== verification/wdt_pin_model.sv ====
// far side of the retrigger line: pull-down, free toggler or loopback
// assumes oe_n low means the watchdog itself drives the line
`timescale 1ns/10ps
module wdt_pin_model (
    input  wire logic clk_in,
    input  wire logic toggle_en_in,
    input  wire logic loop_en_in,
    input  wire logic timeout_in,
    input  wire logic drive_in,
    input  wire logic oe_n_in,
    output logic      pin_out
);
    logic [3:0] div_q;
    logic       lvl_q;
    initial div_q = 4'h0;
    initial lvl_q = 1'b0;
    // one level change every ten clocks, so each edge kind every twenty
    always @(posedge clk_in) begin
        div_q <= (div_q == 4'h9) ? 4'h0 : div_q + 4'h1;
        if (div_q == 4'h9) lvl_q <= ~lvl_q;
    end
    // wired line; the pull-down wins when nobody drives
    always_comb begin
        if (!oe_n_in) pin_out = drive_in;
        else if (loop_en_in) pin_out = timeout_in;
        else if (toggle_en_in) pin_out = lvl_q;
        else pin_out = 1'b0;
    end
endmodule // wdt_pin_model

// ==== verification/test_dual_stage_watchdog.sv ====
// self-checking bench for the watchdog, both variants on one bus, shortened timebase
// assumes the register map and bit positions of wdt_defines.svh
`include "wdt_defines.svh"
`timescale 1ns/10ps
module test_dual_stage_watchdog;
    localparam int TK = 8; // ticks of 8 clocks keep runs short
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wr_data = 16'h0000;
    logic        wr_strobe = 1'b0;
    logic        rd_strobe = 1'b0;
    logic        toggle_en = 1'b0;
    logic        loop_en = 1'b0;
    logic [15:0] rd_data;
    logic        pin, pin_drv, pin_oe_n, tmo, hw_rst, smi, nmi;
    logic        pin_drv_a, pin_oe_n_a, tmo_a, smi_a;
    logic [15:0] d;
    int          failures = 0;
    int          total_checks = 0;
    int          n, l1, l2;

    always #25 clk_in = ~clk_in;

    dual_stage_watchdog #(.VARIANT_B(1'b1), .TICK_CYCLES(TK)) u_dual_stage_watchdog (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wr_data_in(wr_data),
        .wr_strobe_in(wr_strobe), .rd_strobe_in(rd_strobe), .rd_data_out(rd_data),
        .external_retrigger_input_in(pin), .external_retrigger_input_out(pin_drv),
        .external_retrigger_oe_n_out(pin_oe_n), .timeout_output_out(tmo),
        .hw_reset_out(hw_rst), .smi_out(smi), .nmi_out(nmi));

    // variant a listens to the same bus and line; only its own outputs are judged
    dual_stage_watchdog #(.VARIANT_B(1'b0), .TICK_CYCLES(TK)) u_dual_stage_watchdog_a (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wr_data_in(wr_data),
        .wr_strobe_in(wr_strobe), .rd_strobe_in(rd_strobe), .rd_data_out(),
        .external_retrigger_input_in(pin), .external_retrigger_input_out(pin_drv_a),
        .external_retrigger_oe_n_out(pin_oe_n_a), .timeout_output_out(tmo_a),
        .hw_reset_out(), .smi_out(smi_a), .nmi_out());

    wdt_pin_model u_wdt_pin_model (
        .clk_in(clk_in), .toggle_en_in(toggle_en), .loop_en_in(loop_en),
        .timeout_in(tmo), .drive_in(pin_drv), .oe_n_in(pin_oe_n), .pin_out(pin));

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_in);
        wr_strobe <= 1'b1;
        addr <= a;
        wr_data <= v;
        @(posedge clk_in);
        wr_strobe <= 1'b0;
    endtask

    // data stand only in the cycle after the read edge; taken at its closing edge
    task rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_in);
        rd_strobe <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd_strobe <= 1'b0;
        @(posedge clk_in);
        v = rd_data;
    endtask

    // software always loads both counts before enable, delay one included
    task cfg(input logic [15:0] a, input logic [15:0] b, input logic [15:0] o);
        wr(`WDT_REG_CMD, 16'h0002);
        wr(`WDT_REG_LOAD1, a);
        wr(`WDT_REG_LOAD2, b);
        wr(`WDT_REG_OPTIONS, o);
        wr(`WDT_REG_CMD, 16'h0001);
    endtask

    // bounded wait on nmi (0), hw reset (1), timeout (2), variant a smi (3)
    // or variant a timeout (4); n=bound if unseen
    task wait_sig(input int which, input int bound, output int cnt);
        logic s;
        cnt = bound;
        for (int i = 0; i < bound; i++) begin
            @(posedge clk_in);
            s = (which == 0) ? nmi : (which == 1) ? hw_rst : (which == 2) ? tmo :
                (which == 3) ? smi_a : tmo_a;
            if (s === 1'b1) begin
                cnt = i;
                break;
            end
        end
    endtask

    task give_verdict;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // hang guard, well beyond the twelve hundred or so cycles the tests need
    initial begin
        #(50 * 30000);
        failures++;
        give_verdict;
    end

    initial begin
        void'($urandom(47076));
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(`WDT_REG_STATUS, d);
        chk(d, 16'h0000);
        rd(4'hf, d);
        chk(d, 16'h0000);
        // delay path with random loads, nmi then late reset
        l1 = 1 + $urandom % 6;
        l2 = $urandom % 8;
        cfg(l1[15:0], l2[15:0], 16'h0002);
        rd(`WDT_REG_STATUS, d);
        chk(d, 16'h0011);
        wait_sig(0, (l1 + 3) * TK, n);
        chk(n < (l1 + 3) * TK, 1'b1);
        chk(hw_rst, 1'b0);
        chk(tmo, 1'b1);
        chk(smi, 1'b0);
        chk(pin_oe_n, 1'b1);
        wait_sig(1, (l2 + 3) * TK, n);
        chk(hw_rst, 1'b1);
        chk(n >= l2 * TK, 1'b1);
        // immediate reset, zero delay load as corner
        cfg(16'h0001, 16'h0000, 16'h0012);
        wait_sig(0, 4 * TK, n);
        chk(hw_rst, 1'b1);
        rd(`WDT_REG_STATUS, d);
        chk(d & 16'h0006, 16'h0004);
        // widest loads, then hold while disabled
        cfg(16'hffff, 16'hffff, 16'h0000);
        wr(`WDT_REG_CMD, 16'h0002);
        repeat (5 * TK) @(posedge clk_in);
        rd(`WDT_REG_COUNT, d);
        chk(d[15:8], 8'hff);
        chk(d[5:0] >= 6'h3d, 1'b1);
        rd(`WDT_REG_STATUS, d);
        chk(d[0], 1'b0);
        wr(`WDT_REG_CMD, 16'h0004);
        rd(`WDT_REG_STATUS, d);
        chk(d & 16'h0013, 16'h0011);
        rd(`WDT_REG_COUNT, d);
        chk(d[5:0] >= 6'h3e, 1'b1);
        // software retrigger inside the interval keeps it alive
        cfg(16'h0003, 16'h0004, 16'h0002);
        for (int i = 0; i < 6; i++) begin
            repeat (18) @(posedge clk_in);
            wr(`WDT_REG_CMD, 16'h0004);
        end
        rd(`WDT_REG_STATUS, d);
        chk(d & 16'h0006, 16'h0000);
        // pin edges retrigger only with the enable bit
        toggle_en <= 1'b1;
        cfg(16'h0003, 16'h0004, 16'h000a);
        wait_sig(0, 150, n);
        chk(n, 150);
        // other edge kind: b falls, a rises, both stay alive
        cfg(16'h0003, 16'h0004, 16'h000b);
        wait_sig(3, 150, n);
        chk(n, 150);
        wait_sig(0, 150, n);
        chk(n, 150);
        cfg(16'h0003, 16'h0004, 16'h0002);
        wait_sig(0, 150, n);
        chk(n < 150, 1'b1);
        toggle_en <= 1'b0;
        // early timeout looped back never expires; open loop shows lead
        loop_en <= 1'b1;
        l1 = 1 + $urandom % 4;
        cfg(l1[15:0], 16'h0004, 16'h000e);
        wait_sig(0, 200, n);
        chk(n, 200);
        loop_en <= 1'b0;
        cfg(l1[15:0], 16'h0004, 16'h000e);
        wait_sig(2, (l1 + 3) * TK, n);
        chk(nmi, 1'b0);
        wait_sig(0, 3 * TK, n);
        chk(n >= TK - 2 && n <= TK, 1'b1);
        // variant a: warning on both lines in the last tick, then smi
        cfg(16'h0002, 16'h0004, 16'h000f);
        wait_sig(4, 5 * TK, n);
        chk(n < 5 * TK, 1'b1);
        chk(pin_drv_a, 1'b1);
        chk(pin_oe_n_a, 1'b0);
        chk(smi_a, 1'b0);
        wait_sig(3, 2 * TK, n);
        chk(n, TK - 2);
        chk(tmo_a, 1'b0);
        chk(pin_oe_n_a, 1'b1);
        give_verdict;
    end
endmodule // test_dual_stage_watchdog
